// >>> design/flash_rewrite_suspend_control.v
// Overview of operation
// R1: Software sets rewrite enable first, then mode select, to enter interrupt-suspend mode.
// R2: In interrupt-suspend mode software judges completion from the status register only.
// R3: Software sets suspend enable before erase and keeps the suspending interrupt enabled.
// R4: After an erase command no interrupt is acknowledged before the suspend latency; in software-suspend mode the code acknowledges irq_request at once.
// R5: Interrupt-suspend mode: interrupt during erase sets erase suspend request and suspends.
// R6: Clearing erase suspend request while still busy resumes the suspended erase.
// R7: Program suspension needs suspend enable; interrupt acknowledged only after latency; in software-suspend mode the code acknowledges at once.
// R8: Interrupt-suspend mode: interrupt during program sets program suspend request, suspends.
// R9: Clearing program suspend request while still busy resumes the suspended program.
// R10: Ready flag is 0 while programming, erasing or suspended, else 1.
// R11: Flash commands are accepted only while rewrite enable is 1.
// R12: With low blocks enable 0, blocks 0 and 1 reject program and erase.
// R13: With low blocks enable 1, each low block obeys its own disable bit.
// R14: Flash stop resets the control logic, cuts current and blocks access.
// R15: Software sets flash stop when a software-suspend mode operation never finishes.
// R16: Stop or wait with rewrite disabled powers the flash off and back on.
// R17: Program error flag is read-only, 1 after a failed program, else 0.
// R18: Erase error flag is read-only, 1 after a failed erase, else 0.
// R19: Software-suspend mode: writing a suspend request bit 1 suspends the operation.
// R20: Erase active flag is 1 from erase start, through suspension, to its end.
// R21: Program active flag is 1 from program start, through suspension, to its end.
// R22: Read permit flag is 0 while an operation runs and 1 in suspend.
// R23: Clearing rewrite enable forces low blocks enable to 0.
// R24: Clearing rewrite enable forces mode select to 0, software-suspend mode.
// R25: With suspend enable 0, suspend requests are ignored and operations complete.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "flash_rewrite_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_suspend_control #(
  parameter AW = 4,
  parameter BLK_W = 4,
  parameter LATENCY_CYCLES =
    (`SUSPEND_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter LAT_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmd_valid,
  input wire cmd_erase,
  input wire [BLK_W-1:0] cmd_block,
  output reg cmd_accept,
  output reg cmd_reject,
  output reg op_start,
  output reg op_is_erase,
  output reg [BLK_W-1:0] op_block,
  output reg op_suspend,
  input wire op_done,
  input wire op_error,
  input wire irq_request,
  output reg irq_ack,
  input wire stop_wait_mode,
  output reg flash_reset,
  output reg flash_power_on
);
  // ==========================================
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_SUSP = 3'b100;

  // ==========================================
  // Register fields and state
  reg cpu_en_reg;
  reg low_en_reg;
  reg stop_reg;
  reg perr_reg;
  reg eerr_reg;
  reg mode_sel_reg;
  reg blk0_dis_reg;
  reg blk1_dis_reg;
  reg susp_en_reg;
  reg esusp_req_reg;
  reg psusp_req_reg;
  reg eact_reg;
  reg pact_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;

  // ==========================================
  // Register port
  wire wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  reg wr_err;
  reg [31:0] rd_data;
  reg rd_err;
  wire lat_done;

  axil_reg_port #(
    .AW(AW)
  ) u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ==========================================
  // Decode
  wire lane0 = wr_en && wr_strb[0];
  wire wr_stat = lane0 && (wr_addr == `OFS_STATUS_CONTROL);
  wire wr_mode = lane0 && (wr_addr == `OFS_MODE_BLOCK_PROTECT);
  wire wr_susp = lane0 && (wr_addr == `OFS_SUSPEND_CONTROL);
  wire st_idle = state_reg[0];
  wire st_busy = state_reg[1];
  wire st_susp = state_reg[2];
  wire stop_eff = stop_reg && cpu_en_reg; // see R14

  always @* begin
    if (wr_addr == `OFS_STATUS_CONTROL) begin
      wr_err = 1'b0;
    end else if (wr_addr == `OFS_MODE_BLOCK_PROTECT) begin
      wr_err = 1'b0;
    end else if (wr_addr == `OFS_SUSPEND_CONTROL) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr == `OFS_STATUS_CONTROL) begin
      rd_data[`B_READY] = st_idle; // see R10
      rd_data[`B_CPU_EN] = cpu_en_reg;
      rd_data[`B_LOW_EN] = low_en_reg;
      rd_data[`B_STOP] = stop_reg;
      rd_data[`B_PERR] = perr_reg; // see R17
      rd_data[`B_EERR] = eerr_reg; // see R18
    end else if (s_axi_araddr == `OFS_MODE_BLOCK_PROTECT) begin
      rd_data[`B_MODE_SEL] = mode_sel_reg;
      rd_data[`B_BLK0_DIS] = blk0_dis_reg;
      rd_data[`B_BLK1_DIS] = blk1_dis_reg;
      rd_data[`B_FIXED_ONE] = 1'b1;
    end else if (s_axi_araddr == `OFS_SUSPEND_CONTROL) begin
      rd_data[`B_SUSP_EN] = susp_en_reg;
      rd_data[`B_ESUSP_REQ] = esusp_req_reg;
      rd_data[`B_PSUSP_REQ] = psusp_req_reg;
      rd_data[`B_EACT] = eact_reg;
      rd_data[`B_PACT] = pact_reg;
      rd_data[`B_RD_PERMIT] = !st_busy; // see R22
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================
  // Command admission
  wire is_blk0 = (cmd_block == `BLOCK0);
  wire is_blk1 = (cmd_block == `BLOCK1);
  wire blk_ok = is_blk0 ? (low_en_reg && !blk0_dis_reg) : // see R12 R13
                is_blk1 ? (low_en_reg && !blk1_dis_reg) : 1'b1; // see R12 R13
  wire accept = cmd_valid && cpu_en_reg && !stop_eff && st_idle && blk_ok; // see R11

  // ==========================================
  // Suspend control
  wire done_now = st_busy && op_done;
  wire hw_susp = mode_sel_reg && susp_en_reg && irq_request && st_busy &&
                 lat_done && !op_done; // see R3 R4 R7 R25
  wire esusp_set = hw_susp && op_is_erase; // see R5
  wire psusp_set = hw_susp && !op_is_erase; // see R8
  wire esusp_next = esusp_set || (wr_susp ? wr_data[`B_ESUSP_REQ] : esusp_req_reg);
  wire psusp_next = psusp_set || (wr_susp ? wr_data[`B_PSUSP_REQ] : psusp_req_reg);
  wire req_cur = op_is_erase ? esusp_req_reg : psusp_req_reg;
  wire go_susp = st_busy && susp_en_reg && lat_done && req_cur && !op_done; // see R19 R25
  wire go_resume = st_susp && !req_cur; // see R6 R9

  suspend_latency_timer #(
    .CYCLES(LATENCY_CYCLES),
    .W(LAT_W)
  ) u_latency (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(accept),
    .clear(stop_eff),
    .done_reg(lat_done)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (done_now) begin
          state_next = ST_IDLE;
        end else if (go_susp) begin
          state_next = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (go_resume) begin
          state_next = ST_BUSY;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (stop_eff) begin
      state_next = ST_IDLE; // see R14
    end
  end

  // ==========================================
  // Control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_en_reg <= `BIT_CLR;
      low_en_reg <= `BIT_CLR;
      stop_reg <= `BIT_CLR;
      mode_sel_reg <= `BIT_CLR;
      blk0_dis_reg <= `BIT_CLR;
      blk1_dis_reg <= `BIT_CLR;
      susp_en_reg <= `BIT_CLR;
    end else begin
      if (wr_stat) begin
        cpu_en_reg <= wr_data[`B_CPU_EN];
        stop_reg <= wr_data[`B_STOP];
        low_en_reg <= wr_data[`B_LOW_EN] && wr_data[`B_CPU_EN]; // see R23
        if (!wr_data[`B_CPU_EN]) begin
          mode_sel_reg <= `BIT_CLR; // see R24
        end
      end
      if (wr_mode) begin
        if (!(wr_stat && !wr_data[`B_CPU_EN])) begin
          mode_sel_reg <= wr_data[`B_MODE_SEL]; // see R1
        end
        if (cpu_en_reg) begin
          blk0_dis_reg <= wr_data[`B_BLK0_DIS];
          blk1_dis_reg <= wr_data[`B_BLK1_DIS];
        end
      end
      if (wr_susp) begin
        susp_en_reg <= wr_data[`B_SUSP_EN];
      end
    end
  end

  // ==========================================
  // Operation state and flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      esusp_req_reg <= `BIT_CLR;
      psusp_req_reg <= `BIT_CLR;
      eact_reg <= `BIT_CLR;
      pact_reg <= `BIT_CLR;
      perr_reg <= `BIT_CLR;
      eerr_reg <= `BIT_CLR;
      op_is_erase <= `BIT_CLR;
      op_block <= {BLK_W{1'b0}};
    end else begin
      state_reg <= state_next;
      esusp_req_reg <= esusp_next;
      psusp_req_reg <= psusp_next;
      if (stop_eff) begin
        eact_reg <= `BIT_CLR; // see R14
        pact_reg <= `BIT_CLR;
        esusp_req_reg <= esusp_set;
        psusp_req_reg <= psusp_set;
      end else if (accept) begin
        op_is_erase <= cmd_erase;
        op_block <= cmd_block;
        eact_reg <= cmd_erase; // see R20
        pact_reg <= !cmd_erase; // see R21
      end else if (done_now) begin
        eact_reg <= `BIT_CLR; // see R20
        pact_reg <= `BIT_CLR; // see R21
        if (op_is_erase) begin
          eerr_reg <= op_error; // see R18
        end else begin
          perr_reg <= op_error; // see R17
        end
      end
    end
  end

  // ==========================================
  // Outputs to the array engine and CPU
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_accept <= `BIT_CLR;
      cmd_reject <= `BIT_CLR;
      op_start <= `BIT_CLR;
      op_suspend <= `BIT_CLR;
      irq_ack <= `BIT_CLR;
      flash_reset <= `BIT_CLR;
      flash_power_on <= `BIT_SET;
    end else begin
      cmd_accept <= accept;
      cmd_reject <= cmd_valid && !accept; // see R11 R12 R13
      op_start <= accept;
      op_suspend <= state_next[2];
      irq_ack <= irq_request && !(mode_sel_reg && state_next[1]); // see R4 R7
      flash_reset <= stop_eff; // see R14
      flash_power_on <= !stop_eff && !(stop_wait_mode && !cpu_en_reg); // see R14 R16
    end
  end
endmodule // flash_rewrite_suspend_control
`default_nettype wire

// >>> design/flash_rewrite_consts.vh
`ifndef FLASH_REWRITE_CONSTS_VH
`define FLASH_REWRITE_CONSTS_VH
// ==========================================
// Register byte offsets
`define OFS_STATUS_CONTROL 4'h0
`define OFS_MODE_BLOCK_PROTECT 4'h4
`define OFS_SUSPEND_CONTROL 4'h8
// ==========================================
// Status and control field positions
`define B_READY 0
`define B_CPU_EN 1
`define B_LOW_EN 2
`define B_STOP 3
`define B_PERR 6
`define B_EERR 7
// ==========================================
// Mode and block protect field positions
`define B_MODE_SEL 1
`define B_BLK0_DIS 5
`define B_BLK1_DIS 6
`define B_FIXED_ONE 7
// ==========================================
// Suspend control field positions
`define B_SUSP_EN 0
`define B_ESUSP_REQ 1
`define B_PSUSP_REQ 2
`define B_EACT 3
`define B_PACT 4
`define B_RD_PERMIT 6
// ==========================================
// Reset values of single bits
`define BIT_CLR 1'b0
`define BIT_SET 1'b1
// ==========================================
// Bus answers and protected blocks
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BLOCK0 0
`define BLOCK1 1
// ==========================================
// Timing
`define SUSPEND_LATENCY_NS 20000
`define CLK_PERIOD_NS 8
`endif

// >>> design/suspend_latency_timer.v
`include "flash_rewrite_consts.vh"
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Suspend latency timer
module suspend_latency_timer #(
  parameter CYCLES = 2500,
  parameter W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire clear,
  output reg done_reg
);
  reg [W-1:0] count_reg;
  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_reg <= {W{1'b0}};
      done_reg <= `BIT_CLR;
    end else if (start) begin
      count_reg <= CYCLES[W-1:0];
      done_reg <= `BIT_CLR;
    end else if (count_reg != {W{1'b0}}) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
      done_reg <= (count_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule // suspend_latency_timer
`default_nettype wire

// >>> design/axil_reg_port.v
`include "flash_rewrite_consts.vh"
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// AXI4-Lite slave front end
module axil_reg_port #(
  parameter AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wr_en,
  output reg [AW-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  input wire [31:0] rd_data,
  input wire rd_err
);
  // Write path: address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= `BIT_SET;
      s_axi_wready <= `BIT_SET;
      s_axi_bvalid <= `BIT_CLR;
      s_axi_bresp <= `RESP_OKAY;
      wr_en <= `BIT_CLR;
      wr_addr <= {AW{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= `BIT_CLR;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= `BIT_CLR;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      wr_en <= !s_axi_awready && !s_axi_wready && !wr_en && !s_axi_bvalid;
      if (wr_en) begin
        s_axi_bvalid <= `BIT_SET;
        s_axi_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= `BIT_CLR;
        s_axi_awready <= `BIT_SET;
        s_axi_wready <= `BIT_SET;
      end
    end
  end
  // Read path: data captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= `BIT_SET;
      s_axi_rvalid <= `BIT_CLR;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= `BIT_CLR;
      s_axi_rvalid <= `BIT_SET;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= `BIT_CLR;
      s_axi_arready <= `BIT_SET;
    end
  end
endmodule // axil_reg_port
`default_nettype wire

// >>> dv/flash_rewrite_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker
module flash_rewrite_monitor #(
  parameter LATENCY_CYCLES = 2500
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  input wire logic cmd_accept,
  input wire logic cmd_reject,
  input wire logic op_start,
  input wire logic op_suspend,
  input wire logic stop_wait_mode,
  input wire logic flash_reset,
  input wire logic flash_power_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] since_start;
  // ==========================================
  // Cycles since the last start
  always @(posedge aclk) begin
    if (!aresetn) since_start <= 32'h0;
    else if (op_start) since_start <= 32'h1;
    else if (since_start < LATENCY_CYCLES) since_start <= since_start + 32'h1;
  end
  sequence cmd_taken;
    cmd_valid;
  endsequence
  sequence one_answer;
    cmd_accept ^ cmd_reject;
  endsequence
  cmd_answer_a: assert property (cmd_taken |=> one_answer)
    else $error("command not answered once");
  start_pulse_a: assert property (op_start == cmd_accept)
    else $error("start differs from accept");
  suspend_latency_a: assert property ($rose(op_suspend) |-> since_start >= LATENCY_CYCLES - 1)
    else $error("suspend before latency");
  busy_refuse_a: assert property (op_suspend && cmd_valid |=> cmd_reject)
    else $error("command taken while suspended");
  stop_refuse_a: assert property (cmd_valid ##1 flash_reset |-> cmd_reject)
    else $error("command taken while stopped");
  stop_power_a: assert property (flash_reset |-> !flash_power_on)
    else $error("power on while stopped");
  power_back_a: assert property (!stop_wait_mode && !flash_reset ##1 !stop_wait_mode && !flash_reset
    |-> flash_power_on)
    else $error("power not restored");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
endmodule // flash_rewrite_monitor
bind flash_rewrite_suspend_control flash_rewrite_monitor #(.LATENCY_CYCLES(LATENCY_CYCLES)) mon_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cmd_valid, .cmd_accept, .cmd_reject, .op_start, .op_suspend, .stop_wait_mode,
  .flash_reset, .flash_power_on);
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int LAT = 8;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, cmd_block = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic cmd_valid = 0, cmd_erase = 0, op_done = 0, op_error = 0, irq_request = 0;
  logic stop_wait_mode = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cmd_accept, cmd_reject, op_start, op_is_erase, op_suspend, irq_ack;
  wire flash_reset, flash_power_on;
  wire [3:0] op_block;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #4 aclk = ~aclk;
  flash_rewrite_suspend_control #(.LATENCY_CYCLES(LAT)) flash_rewrite_suspend_control_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_erase, .cmd_block,
    .cmd_accept, .cmd_reject, .op_start, .op_is_erase, .op_block, .op_suspend, .op_done,
    .op_error, .irq_request, .irq_ack, .stop_wait_mode, .flash_reset, .flash_power_on);
  // ==========================================
  // Checks and bus tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    chk({7'h0, g}, {7'h0, e}, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk({6'h0, s_axi_bresp}, {6'h0, r}, "write response");
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata[7:0], e, "read data");
    chk({6'h0, s_axi_rresp}, (a inside {4'h0, 4'h4, 4'h8}) ? 8'h00 : 8'h02, "read resp");
  endtask
  task automatic cmd(input logic e, input logic [3:0] b, input logic acc);
    @(posedge aclk);
    cmd_valid <= 1;
    cmd_erase <= e;
    cmd_block <= b;
    @(posedge aclk);
    cmd_valid <= 0;
    @(posedge aclk);
    chk1(cmd_accept, acc, "accept");
    chk1(cmd_reject, !acc, "reject");
  endtask
  task automatic fin(input logic err);
    @(posedge aclk);
    op_done <= 1;
    op_error <= err;
    @(posedge aclk);
    op_done <= 0;
    cyc(2);
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude;
    end
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h80);
    rd(4'h8, 8'h40);
    wr(4'hC, 8'hFF, 2'h2);
    rd(4'hC, 8'h00);
    cmd(1, 4'h2, 0);
    $display("test reset done");
    wr(4'h0, 8'h02, 2'h0);
    cmd(0, 4'h0, 0);
    cmd(1, 4'h1, 0);
    wr(4'h0, 8'h06, 2'h0);
    wr(4'h4, 8'hA0, 2'h0);
    cmd(1, 4'h0, 0);
    cmd(1, 4'h1, 1);
    rd(4'h0, 8'h06);
    rd(4'h8, 8'h08);
    fin(1);
    rd(4'h0, 8'h87);
    rd(4'h8, 8'h40);
    $display("test protect done");
    cmd(0, 4'h2, 1);
    wr(4'h8, 8'h05, 2'h0);
    cyc(LAT + 4);
    chk1(op_suspend, 1, "sw suspend");
    rd(4'h8, 8'h55);
    rd(4'h0, 8'h86);
    cmd(1, 4'h3, 0);
    fin(0);
    chk1(op_suspend, 1, "done ignored");
    wr(4'h8, 8'h01, 2'h0);
    cyc(2);
    chk1(op_suspend, 0, "sw resume");
    fin(0);
    rd(4'h0, 8'h87);
    wr(4'h0, 8'hC6, 2'h0);
    rd(4'h0, 8'h87);
    $display("test software suspend done");
    wr(4'h8, 8'h06, 2'h0);
    cmd(1, 4'h3, 1);
    cyc(LAT + 4);
    chk1(op_suspend, 0, "no suspend");
    fin(0);
    rd(4'h0, 8'h07);
    $display("test suspend disabled done");
    wr(4'h4, 8'h82, 2'h0);
    wr(4'h8, 8'h01, 2'h0);
    for (int k = 0; k < 2; k++) begin
      irq_request <= 1;
      cmd(k == 0, 4'h2, 1);
      chk1(irq_ack, 0, "early ack");
      cyc(LAT + 4);
      chk1(op_suspend, 1, "irq suspend");
      chk1(irq_ack, 1, "late ack");
      chk1(op_is_erase, k == 0, "kind");
      chk({4'h0, op_block}, 8'h02, "block");
      rd(4'h8, (k == 0) ? 8'h4B : 8'h55);
      irq_request <= 0;
      wr(4'h8, 8'h01, 2'h0);
      cyc(2);
      chk1(op_suspend, 0, "irq resume");
      rd(4'h0, 8'h06);
      fin(0);
    end
    $display("test interrupt suspend done");
    wr(4'h0, 8'h00, 2'h0);
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h80);
    stop_wait_mode <= 1;
    cyc(3);
    chk1(flash_power_on, 0, "power off");
    stop_wait_mode <= 0;
    cyc(3);
    chk1(flash_power_on, 1, "power on");
    wr(4'h0, 8'h02, 2'h0);
    cmd(0, 4'h2, 1);
    wr(4'h0, 8'h0A, 2'h0);
    cyc(2);
    chk1(flash_reset, 1, "stop");
    rd(4'h0, 8'h0B);
    rd(4'h8, 8'h41);
    cmd(1, 4'h2, 0);
    wr(4'h0, 8'h02, 2'h0);
    cyc(2);
    chk1(flash_reset, 0, "stop clear");
    $display("test mode and stop done");
    conclude;
  end
endmodule // tb
`default_nettype wire
